// ==== verification/shcp_host_model.sv ====
`timescale 1ns/1ps
module shcp_host_model (
   input wire        clock,
   input wire        txd,
   input wire [15:0] bit_div,
   output reg        rxd
);
   logic [7:0] rx_q[$];
   initial rxd = 1'b1;
   // No handshake: bytes go out whenever asked
   task automatic send_byte(input logic [7:0] b);
      integer i;
      rxd <= 1'b0;
      repeat (bit_div) @(posedge clock);
      for (i = 0; i < 8; i++) begin
         rxd <= b[i];
         repeat (bit_div) @(posedge clock);
      end
      rxd <= 1'b1;
      repeat (bit_div) @(posedge clock);
   endtask
   always begin : rx_side
      logic [7:0] v;
      integer i;
      @(negedge txd);
      repeat (bit_div / 2) @(posedge clock);
      for (i = 0; i < 8; i++) begin
         repeat (bit_div) @(posedge clock);
         v[i] = txd;
      end
      repeat (bit_div) @(posedge clock);
      // Bad stop bit marks the byte as garbage
      rx_q.push_back((txd === 1'b1) ? v : 8'hEE);
   end
endmodule // shcp_host_model

// ==== verification/shcp_top_bench.sv ====
`timescale 1ns/1ps
module shcp_top_bench;
   localparam CLK_HZ = 384000;
   reg         clock, rst_n, reg_wr, reg_rd, arrow_btn, manual_data;
   reg  [7:0]  reg_addr;
   reg  [31:0] reg_wdata, rv;
   reg  [15:0] bit_div;
   wire [31:0] reg_rdata;
   wire        rxd, txd, power_indicator, link_ready_indicator, disp_show;
   wire [1:0]  disp_view;
   wire [3:0]  disp_len;
   integer     failures, comparisons, cycles, i, k;
   integer     rates [0:5] = '{1200, 2400, 4800, 9600, 19200, 38400};
   shcp_top #(.CLK_HZ(CLK_HZ)) DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rxd(rxd), .txd(txd), .arrow_btn(arrow_btn), .manual_data(manual_data),
      .power_indicator(power_indicator), .link_ready_indicator(link_ready_indicator),
      .disp_view(disp_view), .disp_show(disp_show), .disp_len(disp_len));
   shcp_host_model host (.clock(clock), .txd(txd), .bit_div(bit_div), .rxd(rxd));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task summarize;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures = failures + 1;
         summarize;
      end
   end
   task check(input [31:0] seen, input [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Every task starts just after a rising edge
   task wr(input [7:0] a, input [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask
   task rd(input [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      @(posedge clock);
   endtask
   task rdchk(input [7:0] a, input [31:0] m, input [31:0] e);
      rd(a);
      check(rv & m, e);
   endtask
   task wait_idle;
      rd(8'h01);
      for (k = 0; k < 2000 && rv[0] !== 1'b0; k++) rd(8'h01);
   endtask
   task wait_rx(input integer n);
      for (k = 0; k < 20000 && host.rx_q.size() < n; k++) @(posedge clock);
   endtask
   task frame(input [7:0] b0, b1, b2, b3);
      host.send_byte(b0);
      host.send_byte(b1);
      host.send_byte(b2);
      host.send_byte(b3);
      repeat (4) @(posedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
      arrow_btn = 1'b0; manual_data = 1'b0; bit_div = CLK_HZ / 9600;
      failures = 0; comparisons = 0; cycles = 0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      check(power_indicator, 1);
      check(link_ready_indicator, 1);
      rdchk(8'h00, 32'h7F07, 32'h0003);
      for (i = 0; i < 4; i++) begin
         rdchk(8'h04 + i, 32'hFF, 32'h99);
         rdchk(8'h08 + i, 32'h1, 32'h0);
         rdchk(8'h0C + i, 32'hFFFFFFFF, 32'h0);
      end
      wr(8'h04, 32'h00);
      wr(8'h07, 32'hFF);
      rdchk(8'h04, 32'hFF, 32'h00);
      rdchk(8'h07, 32'hFF, 32'hFF);
      wr(8'h00, 32'h6406);
      rdchk(8'h00, 32'h7F07, 32'h6403);
      wr(8'h00, 32'h6503);
      rdchk(8'h00, 32'h7F07, 32'h6403);
      wr(8'h00, 32'h0003);
      rdchk(8'h20, 32'hFFFFFFFF, 32'h0);
      wait_rx(4);
      check({host.rx_q[0], host.rx_q[1]}, 16'h3230);
      check({host.rx_q[2], host.rx_q[3]}, 16'h6203);
      rdchk(8'h01, 32'h40, 32'h40);
      // Host frames: good sum, bad sum, hash-CR end with trailing LF
      frame(8'h56, 8'h45, 8'h9B, 8'h03);
      rdchk(8'h01, 32'h2E, 32'h0A);
      frame(8'h56, 8'h45, 8'h9C, 8'h03);
      rdchk(8'h01, 32'h20, 32'h20);
      rdchk(8'h03, 32'hFF, 32'h03);
      frame(8'h56, 8'h45, 8'h23, 8'h0D);
      host.send_byte(8'h0A);
      rdchk(8'h01, 32'h10, 32'h10);
      for (i = 0; i < 6; i++) begin
         wait_idle;
         wr(8'h00, i);
         bit_div <= CLK_HZ / rates[i];
         host.rx_q.delete();
         wr(8'h02, 8'hA5 ^ i);
         wait_rx(1);
         check(host.rx_q[0], 8'hA5 ^ i);
      end
      wait_idle;
      // Six characters A5h^i sent, none of them end-of-text: sum wraps to D7h
      rdchk(8'h03, 32'hFF00, 32'hD700);
      wr(8'h00, 32'h0003);
      bit_div <= CLK_HZ / 9600;
      wr(8'h12, 32'd20);
      // Display length trails the setting by one cycle
      @(posedge clock);
      check(disp_len, 4'hC);
      wr(8'h12, 32'd5);
      @(posedge clock);
      check(disp_len, 4'h5);
      for (i = 1; i < 4; i++) begin
         arrow_btn <= 1'b1;
         repeat (6) @(posedge clock);
         arrow_btn <= 1'b0;
         repeat (6) @(posedge clock);
         check(disp_view, i % 3);
      end
      wr(8'h11, 32'h3);
      repeat (3) @(posedge clock);
      check(disp_show, 0);
      manual_data <= 1'b1;
      repeat (6) @(posedge clock);
      check(disp_show, 1);
      manual_data <= 1'b0;
      wr(8'h10, 32'h0233);
      rdchk(8'h10, 32'h0333, 32'h0233);
      wr(8'h08, 32'h1);
      wr(8'h0C, 32'hDEADBEEF);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      rdchk(8'h08, 32'h1, 32'h0);
      rdchk(8'h0C, 32'hFFFFFFFF, 32'h0);
      summarize;
   end
endmodule // shcp_top_bench

// ==== verification/shcp_top_monitor.sv ====
`timescale 1ns/1ps
module shcp_top_monitor #(parameter CLK_HZ = 40000000) (
   input wire        clock,
   input wire        rst_n,
   input wire [7:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata,
   input wire        rxd,
   input wire        txd,
   input wire        arrow_btn,
   input wire        manual_data,
   input wire        power_indicator,
   input wire        link_ready_indicator,
   input wire [1:0]  disp_view,
   input wire        disp_show,
   input wire [3:0]  disp_len
);
   // Longest legal low run: start plus eight zero bits at the slowest rate
   localparam int MAX_LOW = 9 * (CLK_HZ / 1200) + 2;
   reg [31:0] low_run_r;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) low_run_r <= 32'h0;
      else low_run_r <= txd ? 32'h0 : low_run_r + 32'h1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   a_lamps_lit: assert property ($past(rst_n) |-> power_indicator && link_ready_indicator)
      else $error("indicator dark while running");
   a_len_cap: assert property (disp_len <= 4'hC)
      else $error("display length above twelve");
   a_view_legal: assert property (disp_view != 2'h3)
      else $error("illegal display view");
   a_view_step: assert property (disp_view != $past(disp_view) |->
      disp_view == (($past(disp_view) == 2'h2) ? 2'h0 : $past(disp_view) + 2'h1))
      else $error("view skipped a step");
   a_manual_shown: assert property (manual_data [*5] |=> disp_show)
      else $error("manual data not shown");
   a_low_run: assert property (low_run_r <= MAX_LOW)
      else $error("line held spacing too long");
   a_ready_soon: assert property ($rose(rst_n) |-> ##[0:200] !txd)
      else $error("ready frame did not start");
   a_baud_range: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[2:0] <= 3'h5)
      else $error("baud field out of range");
   a_tmo_range: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[14:8] <= 7'h64)
      else $error("timeout out of range");
   a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without read");
   c_full_len: cover property (disp_len == 4'hC);
   c_tx_start: cover property ($fell(txd));
   c_manual: cover property (manual_data && disp_show);
endmodule // shcp_top_monitor
bind shcp_top shcp_top_monitor #(.CLK_HZ(CLK_HZ)) u_mon (.clock(clock), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd), .arrow_btn(arrow_btn),
   .manual_data(manual_data), .power_indicator(power_indicator),
   .link_ready_indicator(link_ready_indicator), .disp_view(disp_view),
   .disp_show(disp_show), .disp_len(disp_len));

// ==== verilog/shcp_map.vh ====
`ifndef SHCP_MAP_VH
`define SHCP_MAP_VH
// Register indices (byte address = 4 * index)
`define SHCP_IDX_CTRL       8'h00
`define SHCP_IDX_STATUS     8'h01
`define SHCP_IDX_TXDATA     8'h02
`define SHCP_IDX_RXDATA     8'h03
`define SHCP_IDX_TAGTYPE    8'h04
`define SHCP_IDX_PWMODE     8'h08
`define SHCP_IDX_PASSWORD   8'h0C
`define SHCP_IDX_HEADCFG    8'h10
`define SHCP_IDX_DISPCTRL   8'h11
`define SHCP_IDX_DISPDATA   8'h12
// Control fields
`define SHCP_CTRL_BAUD_LSB  0
`define SHCP_CTRL_BAUD_MSB  2
`define SHCP_CTRL_TMO_LSB   8
`define SHCP_CTRL_TMO_MSB   14
// Status fields
`define SHCP_ST_TXBUSY      0
`define SHCP_ST_RXVALID     1
`define SHCP_ST_FRAMEERR    2
`define SHCP_ST_CMD_CSUM    3
`define SHCP_ST_CMD_TERM    4
`define SHCP_ST_CSUM_BAD    5
`define SHCP_ST_READY_DONE  6
// Baud codes
`define SHCP_BAUD_1200      3'h0
`define SHCP_BAUD_2400      3'h1
`define SHCP_BAUD_4800      3'h2
`define SHCP_BAUD_9600      3'h3
`define SHCP_BAUD_19200     3'h4
`define SHCP_BAUD_38400     3'h5
// Reset values
`define SHCP_RST_BAUD       3'h3
`define SHCP_RST_TMO        7'h00
`define SHCP_RST_TAGTYPE    8'h99
`define SHCP_RST_PASSWORD   32'h00000000
// Characters
`define SHCP_CH_ETX         8'h03
`define SHCP_CH_HASH        8'h23
`define SHCP_CH_CR          8'h0D
`define SHCP_CH_LF          8'h0A
`define SHCP_CH_STATUS      8'h32
`define SHCP_CH_HEAD0       8'h30
// Timing and display
`define SHCP_CLK_HZ         40000000
`define SHCP_DISP_CHARS     12
`define SHCP_VIEW_HEXDELIM  2'h0
`define SHCP_VIEW_HEXPLAIN  2'h1
`define SHCP_VIEW_ASCII     2'h2
`endif

// ==== verilog/shcp_top.v ====
`timescale 1ns/1ps
`include "shcp_map.vh"
// Behaviour
// - Baud 1200..38400 in six steps, chosen by a control field.
// - Reset default is 9600 baud and response timeout zero.
// - Characters are 1 start, 8 data, no parity, 1 stop, fixed.
// - No flow control; every arriving character with a good stop bit is accepted.
// - After reset send ready frame '2','0', checksum, end-of-text.
// - Checksum is low byte of sum of preceding characters, then 03h.
// - Also accept commands ended by hash, CR, optional LF.
// - Settings split into retained and power-cycle volatile classes; here every setting resets with rst_n.
// - Password mode off and password zero after every reset.
// - Per-head tag type accepts 00..FF, defaults to 99h.
// - Four heads; positions 3 and 4 may be triggers tied to one head.
// - Display shows at most the first 12 tag characters.
// - Arrow presses cycle hex delimited, hex plain, ASCII views.
// - Manually started tag data shown regardless of menu level.
// - Power and link-ready indicators lit once supply present.
module shcp_top (
   clock,
   rst_n,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   rxd,
   txd,
   arrow_btn,
   manual_data,
   power_indicator,
   link_ready_indicator,
   disp_view,
   disp_show,
   disp_len
);
   parameter CLK_HZ = `SHCP_CLK_HZ;

   input  wire [7:0]  reg_addr;
   input  wire        clock;
   input  wire        rst_n;
   input  wire [31:0] reg_wdata;
   input  wire        reg_wr;
   input  wire        reg_rd;
   output reg  [31:0] reg_rdata;
   input  wire        rxd;
   output reg         txd;
   input  wire        arrow_btn;
   input  wire        manual_data;
   output reg         power_indicator;
   output reg         link_ready_indicator;
   output reg  [1:0]  disp_view;
   output reg         disp_show;
   output reg  [3:0]  disp_len;

   localparam TX_IDLE  = 2'h0;
   localparam TX_SHIFT = 2'h1;
   localparam RD_STAT  = 2'h0;
   localparam RD_HEAD  = 2'h1;
   localparam RD_CSUM  = 2'h2;
   localparam RD_ETX   = 2'h3;

   // Cycles per bit, minus one, for a baud code
   function [15:0] baud_div;
      input [2:0] code;
      reg   [31:0] rate;
      reg   [31:0] cyc;
      begin
         rate = 32'd9600;
         case (code)
            `SHCP_BAUD_1200:  rate = 32'd1200;
            `SHCP_BAUD_2400:  rate = 32'd2400;
            `SHCP_BAUD_4800:  rate = 32'd4800;
            `SHCP_BAUD_19200: rate = 32'd19200;
            `SHCP_BAUD_38400: rate = 32'd38400;
            default:          rate = 32'd9600;
         endcase
         cyc      = CLK_HZ / rate - 1;
         // Slowest rate still fits sixteen bits at the default clock
         baud_div = cyc[15:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Settings
   reg [2:0]  baud_r;
   reg [6:0]  tmo_r;
   reg [7:0]  tag_r [0:3];
   reg [3:0]  pwmode_r;
   reg [31:0] pw_r [0:3];
   reg [1:0]  trig3_head_r;
   reg [1:0]  trig4_head_r;
   reg [1:0]  trig_en_r;
   reg [3:0]  menu_lvl_r;
   reg [3:0]  tag_len_r;
   reg        tag_new_r;
   reg        tag_manual_r;
   reg        frame_err_r;
   reg        cmd_csum_r;
   reg        cmd_term_r;
   reg        csum_bad_r;
   reg        rx_valid_r;
   reg [7:0]  rx_hold_r;
   integer    i;

   wire [15:0] bit_div = baud_div(baud_r);
   wire [7:0]  rx_data;
   wire        rx_stb;
   wire        rx_ferr;
   wire [1:0]  idx_lo = reg_addr[1:0];

   shcp_uart_rx u_rx (
      .clock   (clock),
      .rst_n   (rst_n),
      .bit_div (bit_div),
      .rxd     (rxd),
      .rx_data (rx_data),
      .rx_stb  (rx_stb),
      .rx_ferr (rx_ferr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter and ready frame
   reg [1:0]  tx_state_r;
   reg [15:0] tx_cnt_r;
   reg [3:0]  tx_bit_r;
   reg [9:0]  tx_shift_r;
   reg        rdy_busy_r;
   reg [1:0]  rdy_step_r;
   reg        rdy_done_r;
   reg        sw_tx_pend_r;
   reg [7:0]  sw_tx_r;
   reg [7:0]  tx_sum_r;
   wire       tx_free = (tx_state_r == TX_IDLE);
   wire       tx_wr = reg_wr && (reg_addr == `SHCP_IDX_TXDATA);
   // Running sum wraps at 8 bits on purpose
   wire [7:0] rdy_csum = `SHCP_CH_STATUS + `SHCP_CH_HEAD0;
   reg  [7:0] rdy_char;

   always @* begin
      case (rdy_step_r)
         RD_STAT: rdy_char = `SHCP_CH_STATUS;
         RD_HEAD: rdy_char = `SHCP_CH_HEAD0;
         RD_CSUM: rdy_char = rdy_csum;
         default: rdy_char = `SHCP_CH_ETX;
      endcase
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_r   <= TX_IDLE;
         tx_cnt_r     <= 16'h0000;
         tx_bit_r     <= 4'h0;
         tx_shift_r   <= 10'h3FF;
         txd          <= 1'b1;
         rdy_busy_r   <= 1'b1;
         rdy_step_r   <= RD_STAT;
         rdy_done_r   <= 1'b0;
         sw_tx_pend_r <= 1'b0;
         sw_tx_r      <= 8'h00;
         tx_sum_r     <= 8'h00;
      end else begin
         if (tx_wr) begin
            sw_tx_pend_r <= 1'b1;
            sw_tx_r      <= reg_wdata[7:0];
         end
         case (tx_state_r)
            TX_IDLE: begin
               txd <= 1'b1;
               if (rdy_busy_r) begin
                  // Frame goes out before any software character
                  tx_shift_r <= {1'b1, rdy_char, 1'b0};
                  tx_state_r <= TX_SHIFT;
                  tx_cnt_r   <= bit_div;
                  tx_bit_r   <= 4'h0;
                  rdy_step_r <= rdy_step_r + 2'h1;
                  if (rdy_step_r == RD_ETX) begin
                     rdy_busy_r <= 1'b0;
                     rdy_done_r <= 1'b1;
                  end
               end else if (sw_tx_pend_r && !tx_wr) begin
                  tx_shift_r   <= {1'b1, sw_tx_r, 1'b0};
                  tx_state_r   <= TX_SHIFT;
                  tx_cnt_r     <= bit_div;
                  tx_bit_r     <= 4'h0;
                  sw_tx_pend_r <= 1'b0;
                  // Software reads this to build its own checksum
                  tx_sum_r     <= (sw_tx_r == `SHCP_CH_ETX) ? 8'h00 : tx_sum_r + sw_tx_r;
               end
            end
            default: begin
               txd <= tx_shift_r[0];
               if (tx_cnt_r == 16'h0000) begin
                  tx_cnt_r   <= bit_div;
                  tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                  tx_bit_r   <= tx_bit_r + 4'h1;
                  if (tx_bit_r == 4'h9) begin
                     tx_state_r <= TX_IDLE;
                  end
               end else begin
                  tx_cnt_r <= tx_cnt_r - 16'h0001;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command end detection
   reg [7:0] rx_sum_r;
   reg [7:0] prev_r;
   reg [7:0] prev2_r;
   reg       after_term_r;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_sum_r     <= 8'h00;
         prev_r       <= 8'h00;
         prev2_r      <= 8'h00;
         after_term_r <= 1'b0;
         cmd_csum_r   <= 1'b0;
         cmd_term_r   <= 1'b0;
         csum_bad_r   <= 1'b0;
         frame_err_r  <= 1'b0;
         rx_valid_r   <= 1'b0;
         rx_hold_r    <= 8'h00;
      end else begin
         if (reg_rd && reg_addr == `SHCP_IDX_STATUS) begin
            cmd_csum_r  <= 1'b0;
            cmd_term_r  <= 1'b0;
            csum_bad_r  <= 1'b0;
            frame_err_r <= 1'b0;
         end
         if (reg_rd && reg_addr == `SHCP_IDX_RXDATA) begin
            rx_valid_r <= 1'b0;
         end
         // Set beats read-clear in the same cycle
         if (rx_ferr) begin
            frame_err_r <= 1'b1;
         end
         if (rx_stb) begin
            rx_valid_r <= 1'b1;
            rx_hold_r  <= rx_data;
            prev_r     <= rx_data;
            prev2_r    <= prev_r;
            if (after_term_r && rx_data == `SHCP_CH_LF) begin
               // Optional LF after hash-CR is swallowed
               after_term_r <= 1'b0;
               rx_sum_r     <= 8'h00;
            end else if (rx_data == `SHCP_CH_ETX) begin
               // Sum excludes the checksum byte itself
               cmd_csum_r   <= 1'b1;
               if (prev_r != (rx_sum_r - prev_r)) begin
                  csum_bad_r <= 1'b1;
               end
               rx_sum_r     <= 8'h00;
               after_term_r <= 1'b0;
            end else if (rx_data == `SHCP_CH_CR && prev_r == `SHCP_CH_HASH) begin
               cmd_term_r   <= 1'b1;
               rx_sum_r     <= 8'h00;
               after_term_r <= 1'b1;
            end else begin
               rx_sum_r     <= rx_sum_r + rx_data;
               after_term_r <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Setting registers; every one of them resets with rst_n
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         baud_r       <= `SHCP_RST_BAUD;
         tmo_r        <= `SHCP_RST_TMO;
         pwmode_r     <= 4'h0;
         trig_en_r    <= 2'h0;
         trig3_head_r <= 2'h0;
         trig4_head_r <= 2'h1;
         menu_lvl_r   <= 4'h0;
         tag_len_r    <= 4'h0;
         tag_new_r    <= 1'b0;
         for (i = 0; i < 4; i = i + 1) begin
            tag_r[i] <= `SHCP_RST_TAGTYPE;
            pw_r[i]  <= `SHCP_RST_PASSWORD;
         end
      end else if (reg_wr) begin
         if (reg_addr == `SHCP_IDX_CTRL) begin
            if (reg_wdata[`SHCP_CTRL_BAUD_MSB:`SHCP_CTRL_BAUD_LSB] <= `SHCP_BAUD_38400) begin
               baud_r <= reg_wdata[`SHCP_CTRL_BAUD_MSB:`SHCP_CTRL_BAUD_LSB];
            end
            // Timeout range is 0..100
            if (reg_wdata[`SHCP_CTRL_TMO_MSB:`SHCP_CTRL_TMO_LSB] <= 7'd100) begin
               tmo_r <= reg_wdata[`SHCP_CTRL_TMO_MSB:`SHCP_CTRL_TMO_LSB];
            end
         end else if (reg_addr[7:2] == `SHCP_IDX_TAGTYPE >> 2) begin
            tag_r[idx_lo] <= reg_wdata[7:0];
         end else if (reg_addr[7:2] == `SHCP_IDX_PWMODE >> 2) begin
            pwmode_r[idx_lo] <= reg_wdata[0];
         end else if (reg_addr[7:2] == `SHCP_IDX_PASSWORD >> 2) begin
            pw_r[idx_lo] <= reg_wdata;
         end else if (reg_addr == `SHCP_IDX_HEADCFG) begin
            // Each trigger names exactly one head
            trig_en_r    <= reg_wdata[1:0];
            trig3_head_r <= reg_wdata[5:4];
            trig4_head_r <= reg_wdata[9:8];
         end else if (reg_addr == `SHCP_IDX_DISPCTRL) begin
            menu_lvl_r <= reg_wdata[3:0];
         end else if (reg_addr == `SHCP_IDX_DISPDATA) begin
            // Longer tag data is clipped
            tag_len_r <= (reg_wdata[7:0] > `SHCP_DISP_CHARS) ? 4'd12 : reg_wdata[3:0];
            tag_new_r <= ~tag_new_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Display, buttons and indicators
   reg [2:0] btn_sync_r;
   reg [1:0] man_sync_r;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         btn_sync_r           <= 3'h0;
         man_sync_r           <= 2'h0;
         disp_view            <= `SHCP_VIEW_HEXDELIM;
         disp_show            <= 1'b0;
         disp_len             <= 4'h0;
         tag_manual_r         <= 1'b0;
         power_indicator      <= 1'b0;
         link_ready_indicator <= 1'b0;
      end else begin
         btn_sync_r <= {btn_sync_r[1:0], arrow_btn};
         man_sync_r <= {man_sync_r[0], manual_data};
         power_indicator      <= 1'b1;
         link_ready_indicator <= 1'b1;
         tag_manual_r <= man_sync_r[1];
         if (btn_sync_r[1] && !btn_sync_r[2]) begin
            // Three views in a ring
            disp_view <= (disp_view == `SHCP_VIEW_ASCII) ? `SHCP_VIEW_HEXDELIM
                                                         : disp_view + 2'h1;
         end
         disp_len <= tag_len_r;
         // Manual results override the menu level
         disp_show <= (menu_lvl_r == 4'h0) || tag_manual_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after the strobe
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= 32'h00000000;
         if (reg_addr == `SHCP_IDX_CTRL) begin
            reg_rdata <= {17'h0, tmo_r, 5'h0, baud_r};
         end else if (reg_addr == `SHCP_IDX_STATUS) begin
            reg_rdata <= {24'h0, 1'b0, rdy_done_r, csum_bad_r, cmd_term_r, cmd_csum_r,
                          frame_err_r, rx_valid_r, ~tx_free | sw_tx_pend_r};
         end else if (reg_addr == `SHCP_IDX_RXDATA) begin
            reg_rdata <= {16'h0, tx_sum_r, rx_hold_r};
         end else if (reg_addr[7:2] == `SHCP_IDX_TAGTYPE >> 2) begin
            reg_rdata <= {24'h0, tag_r[idx_lo]};
         end else if (reg_addr[7:2] == `SHCP_IDX_PWMODE >> 2) begin
            reg_rdata <= {31'h0, pwmode_r[idx_lo]};
         end else if (reg_addr[7:2] == `SHCP_IDX_PASSWORD >> 2) begin
            reg_rdata <= pw_r[idx_lo];
         end else if (reg_addr == `SHCP_IDX_HEADCFG) begin
            reg_rdata <= {22'h0, trig4_head_r, 2'h0, trig3_head_r, 2'h0, trig_en_r};
         end else if (reg_addr == `SHCP_IDX_DISPCTRL) begin
            reg_rdata <= {23'h0, tag_new_r, 2'h0, disp_view, menu_lvl_r};
         end else if (reg_addr == `SHCP_IDX_DISPDATA) begin
            reg_rdata <= {28'h0, tag_len_r};
         end
      end
   end
endmodule // shcp_top

// ==== verilog/shcp_uart_rx.v ====
`timescale 1ns/1ps
`include "shcp_map.vh"
module shcp_uart_rx (
   clock,
   rst_n,
   bit_div,
   rxd,
   rx_data,
   rx_stb,
   rx_ferr
);
   input  wire        clock;
   input  wire        rst_n;
   input  wire [15:0] bit_div;
   input  wire        rxd;
   output reg  [7:0]  rx_data;
   output reg         rx_stb;
   output reg         rx_ferr;

   localparam ST_IDLE  = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_DATA  = 2'h2;
   localparam ST_STOP  = 2'h3;

   reg        sync1_r;
   reg        sync2_r;
   reg [1:0]  state_r;
   reg [15:0] cnt_r;
   reg [2:0]  bit_r;
   reg [7:0]  shift_r;

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         state_r <= ST_IDLE;
         cnt_r   <= 16'h0000;
         bit_r   <= 3'h0;
         shift_r <= 8'h00;
         rx_data <= 8'h00;
         rx_stb  <= 1'b0;
         rx_ferr <= 1'b0;
      end else begin
         sync1_r <= rxd;
         sync2_r <= sync1_r;
         rx_stb  <= 1'b0;
         rx_ferr <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               // First fall to spacing starts a character
               if (!sync2_r) begin
                  state_r <= ST_START;
                  cnt_r   <= {1'b0, bit_div[15:1]};
               end
            end
            ST_START: begin
               if (cnt_r == 16'h0000) begin
                  // Glitch shorter than half a bit is dropped
                  state_r <= sync2_r ? ST_IDLE : ST_DATA;
                  cnt_r   <= bit_div;
                  bit_r   <= 3'h0;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            ST_DATA: begin
               if (cnt_r == 16'h0000) begin
                  shift_r <= {sync2_r, shift_r[7:1]};
                  cnt_r   <= bit_div;
                  if (bit_r == 3'h7) begin
                     state_r <= ST_STOP;
                  end
                  bit_r <= bit_r + 3'h1;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            default: begin
               if (cnt_r == 16'h0000) begin
                  state_r <= ST_IDLE;
                  rx_data <= shift_r;
                  // Never stalls the sender: no flow control
                  rx_stb  <= sync2_r;
                  rx_ferr <= ~sync2_r;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
         endcase
      end
   end
endmodule // shcp_uart_rx
